// ---- hdl/converter_port_pkg.sv ----
// shared types and constants for the converter serial host port
// assumes a 125 MHz system clock and a host-driven serial clock that stops between frames
package converter_port_pkg;
  // serial framing
  localparam int CMD_BITS = 8;
  localparam int RESULT_BITS = 12;
  localparam int FRAME_BITS = 16;
  localparam int BIT_CNT_W = 4;
  localparam logic [BIT_CNT_W-1:0] CMD_LAST_BIT = 4'h7;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 4'h1;
  localparam logic [CMD_BITS-1:0] BYTE_ZERO = 8'h00;
  localparam logic [FRAME_BITS-1:0] FRAME_ZERO = 16'h0000;
  localparam logic [RESULT_BITS-1:0] RESULT_ZERO = 12'h000;
  localparam int SYNC_STAGES = 3;
  localparam logic [SYNC_STAGES-1:0] SYNC_ZERO = 3'h0;
  localparam logic [SYNC_STAGES-1:0] SYNC_ONE = 3'h7;

  // timing: system clock and conversion clock
  localparam int MCLK_PERIOD_PS = 8000;
  localparam int CONV_CLK_PERIOD_PS = 280000;
  // longest-time figure: round down, never under one cycle
  localparam int CONV_DIV_CYCLES = (CONV_CLK_PERIOD_PS / MCLK_PERIOD_PS < 1) ? 1 :
                                   CONV_CLK_PERIOD_PS / MCLK_PERIOD_PS;
  localparam int CONV_CLOCKS = 16;
  localparam int CONV_CNT_W = 16;

  typedef enum logic [1:0] {
    MODE_00 = 2'b00,
    MODE_01 = 2'b01,
    MODE_10 = 2'b10,
    MODE_11 = 2'b11
  } clock_mode_type;

  typedef enum logic {
    CONV_IDLE = 1'b0,
    CONV_BUSY = 1'b1
  } conv_state_type;

  typedef struct packed {
    logic first;
    logic [CMD_BITS-1:0] data;
  } rx_byte_type;
endpackage

// ---- hdl/converter_serial_port.sv ----
// serial host port of the converter: pin-level capture, launch, end-of-conversion flag,
// conversion-start input, DAC load and wake-up select
// assumes the host is serial bus master; sclk_i stands still while cs_n_i is high
//
// Summary of operation
// - End-of-conversion is driven low when a result is ready; data is valid only after the fall.
// - In clock modes 00, 01 and 10 the serial output changes on each serial clock fall.
// - In clock mode 11 the serial output changes on each serial clock rise.
// - While chip select is high the serial output is released (output enable low).
// - The serial interface acts on clock and data only while chip select is low.
// - The serial input is sampled on the serial clock fall in every clock mode.
// - While the DAC load input is low the DAC holding registers pass new codes through.
// - The wake-up select input picks ground (low) or reference (high) for DAC wake-up.
// - The shared pin is a conversion-start input or analog channel eleven by setup.
// - Conversion time is the number of conversion clocks times the conversion clock period.
// - Chip select falling starts a transfer whose first eight bits are a command, MSB first.
// - Chip select rising returns the interface to idle and drops any partial transfer.
`timescale 1ns/1ps
module converter_serial_port
  import converter_port_pkg::*;
#(
  parameter int CONV_CLOCKS_P = CONV_CLOCKS,
  parameter int CONV_DIV_P = CONV_DIV_CYCLES
) (
  // system clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // serial pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  output logic dout_o,
  output logic dout_oe_o,
  output logic eoc_n_o,
  // control pins
  input wire logic convert_start_n_i,
  input wire logic dac_load_n_i,
  input wire logic dac_wakeup_select_i,
  // setup from the register side
  input wire converter_port_pkg::clock_mode_type clock_mode_i,
  input wire logic analog_channel_eleven_i,
  // conversion results in
  input wire logic result_valid_i,
  input wire logic [RESULT_BITS-1:0] result_data_i,
  output logic result_ready_o,
  // received bytes out
  output logic rx_valid_o,
  output converter_port_pkg::rx_byte_type rx_byte_o,
  // conversion control
  output logic conv_busy_o,
  output logic conv_done_o,
  // DAC codes
  input wire logic dac_write_i,
  input wire logic [RESULT_BITS-1:0] dac_code_i,
  output logic [RESULT_BITS-1:0] dac_out_o,
  output logic dac_wakeup_high_o
);
  import converter_port_pkg::*;
  if (CONV_CLOCKS_P < 1 || CONV_CLOCKS_P >= (1 << CONV_CNT_W) ||
      CONV_DIV_P < 1 || CONV_DIV_P >= (1 << CONV_CNT_W)) begin : g_bad_counts
    $error("conversion counts out of range");
  end

  // ---------------- system domain synchronisers ----------------
  logic [SYNC_STAGES-1:0] cs_sync, start_sync, load_sync, rxt_sync, ackt_sync;
  logic rx_toggle, ack_toggle;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cs_sync <= SYNC_ONE;
      start_sync <= SYNC_ONE;
      load_sync <= SYNC_ONE;
      rxt_sync <= SYNC_ZERO;
      ackt_sync <= SYNC_ZERO;
    end else begin
      cs_sync <= {cs_sync[1:0], cs_n_i};
      start_sync <= {start_sync[1:0], convert_start_n_i};
      load_sync <= {load_sync[1:0], dac_load_n_i};
      rxt_sync <= {rxt_sync[1:0], rx_toggle};
      ackt_sync <= {ackt_sync[1:0], ack_toggle};
    end
  end

  // a level counts once stages two and three agree
  logic cs_high, start_n, load_n, rxt_seen, ackt_seen;
  logic next_cs_high, next_start_n, next_load_n, next_rxt_seen, next_ackt_seen;
  always_comb begin
    next_cs_high = (cs_sync[1] == cs_sync[2]) ? cs_sync[2] : cs_high;
    next_start_n = (start_sync[1] == start_sync[2]) ? start_sync[2] : start_n;
    next_load_n = (load_sync[1] == load_sync[2]) ? load_sync[2] : load_n;
    next_rxt_seen = (rxt_sync[1] == rxt_sync[2]) ? rxt_sync[2] : rxt_seen;
    next_ackt_seen = (ackt_sync[1] == ackt_sync[2]) ? ackt_sync[2] : ackt_seen;
  end
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      cs_high <= 1'b1;
      start_n <= 1'b1;
      load_n <= 1'b1;
      rxt_seen <= 1'b0;
      ackt_seen <= 1'b0;
    end else begin
      cs_high <= next_cs_high;
      start_n <= next_start_n;
      load_n <= next_load_n;
      rxt_seen <= next_rxt_seen;
      ackt_seen <= next_ackt_seen;
    end
  end

  // ---------------- system domain: setup, buffer, result hand-off ----------------
  clock_mode_type mode_hold, next_mode_hold;
  logic [RESULT_BITS-1:0] buf_data [2];
  logic [RESULT_BITS-1:0] next_buf0, next_buf1, tx_hold, next_tx_hold;
  logic [1:0] buf_cnt, next_buf_cnt;
  logic tx_full, next_tx_full, ack_last, next_ack_last, rxt_last, next_rxt_last;
  logic next_eoc_n, next_rx_valid, next_result_ready, wake_done, next_wake_done;
  logic next_wakeup_high;
  logic [RESULT_BITS-1:0] next_dac_hold, next_dac_out, dac_hold;
  rx_byte_type rx_hold, next_rx_byte;
  logic push, pop, ack_event;

  always_comb begin
    ack_event = (ackt_seen != ack_last);
    push = result_valid_i && result_ready_o;
    pop = (buf_cnt != 2'd0) && (!tx_full || ack_event);
    next_ack_last = ackt_seen;
    next_buf0 = buf_data[0];
    next_buf1 = buf_data[1];
    next_buf_cnt = buf_cnt;
    if (pop) begin
      next_buf0 = buf_data[1];
      next_buf_cnt = buf_cnt - 2'd1;
    end
    if (push) begin
      if (next_buf_cnt == 2'd0) begin
        next_buf0 = result_data_i;
      end else begin
        next_buf1 = result_data_i;
      end
      next_buf_cnt = next_buf_cnt + 2'd1;
    end
    next_result_ready = (next_buf_cnt != 2'd2);
    // a new word beats the consume of the old one in the same cycle
    next_tx_full = tx_full;
    next_tx_hold = tx_hold;
    if (ack_event) begin
      next_tx_full = 1'b0;
    end
    if (pop) begin
      next_tx_full = 1'b1;
      next_tx_hold = buf_data[0];
    end
    // tx_hold changes only when the link side has let go of it
    next_eoc_n = !next_tx_full;
    // mode is only taken between transfers so the link sees it stable
    next_mode_hold = cs_high ? clock_mode_i : mode_hold;
    next_rxt_last = rxt_seen;
    next_rx_valid = (rxt_seen != rxt_last);
    next_rx_byte = next_rx_valid ? rx_hold : rx_byte_o;
    next_dac_hold = dac_write_i ? dac_code_i : dac_hold;
    next_dac_out = load_n ? dac_out_o : dac_hold;
    next_wake_done = 1'b1;
    next_wakeup_high = wake_done ? dac_wakeup_high_o : dac_wakeup_select_i;
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      buf_data[0] <= RESULT_ZERO;
      buf_data[1] <= RESULT_ZERO;
      buf_cnt <= 2'd0;
      tx_hold <= RESULT_ZERO;
      tx_full <= 1'b0;
      ack_last <= 1'b0;
      eoc_n_o <= 1'b1;
      result_ready_o <= 1'b0;
      mode_hold <= MODE_00;
      rxt_last <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_byte_o <= '0;
      dac_hold <= RESULT_ZERO;
      dac_out_o <= RESULT_ZERO;
      wake_done <= 1'b0;
      dac_wakeup_high_o <= 1'b1;
    end else begin
      buf_data[0] <= next_buf0;
      buf_data[1] <= next_buf1;
      buf_cnt <= next_buf_cnt;
      tx_hold <= next_tx_hold;
      tx_full <= next_tx_full;
      ack_last <= next_ack_last;
      eoc_n_o <= next_eoc_n;
      result_ready_o <= next_result_ready;
      mode_hold <= next_mode_hold;
      rxt_last <= next_rxt_last;
      rx_valid_o <= next_rx_valid;
      rx_byte_o <= next_rx_byte;
      dac_hold <= next_dac_hold;
      dac_out_o <= next_dac_out;
      wake_done <= next_wake_done;
      dac_wakeup_high_o <= next_wakeup_high;
    end
  end

  // ---------------- system domain: conversion timing ----------------
  conv_state_type conv_state, next_conv_state;
  logic [CONV_CNT_W-1:0] div_cnt, next_div_cnt, clk_cnt, next_clk_cnt;
  logic start_last, next_start_last, next_conv_done, start_fall;
  always_comb begin
    next_start_last = start_n;
    // with the pin set as analog channel eleven the start input is ignored
    start_fall = start_last && !start_n && !analog_channel_eleven_i;
    next_conv_state = conv_state;
    next_div_cnt = div_cnt;
    next_clk_cnt = clk_cnt;
    next_conv_done = 1'b0;
    unique case (conv_state)
      CONV_IDLE: begin
        next_div_cnt = '0;
        next_clk_cnt = '0;
        if (start_fall) begin
          next_conv_state = CONV_BUSY;
        end
      end
      CONV_BUSY: begin
        // busy for CONV_CLOCKS_P periods of the divided conversion clock
        if (div_cnt == CONV_CNT_W'(CONV_DIV_P - 1)) begin
          next_div_cnt = '0;
          if (clk_cnt == CONV_CNT_W'(CONV_CLOCKS_P - 1)) begin
            next_conv_state = CONV_IDLE;
            next_conv_done = 1'b1;
          end else begin
            next_clk_cnt = clk_cnt + 1'b1;
          end
        end else begin
          next_div_cnt = div_cnt + 1'b1;
        end
      end
    endcase
  end
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      conv_state <= CONV_IDLE;
      div_cnt <= '0;
      clk_cnt <= '0;
      start_last <= 1'b1;
      conv_busy_o <= 1'b0;
      conv_done_o <= 1'b0;
    end else begin
      conv_state <= next_conv_state;
      div_cnt <= next_div_cnt;
      clk_cnt <= next_clk_cnt;
      start_last <= next_start_last;
      conv_busy_o <= (next_conv_state == CONV_BUSY);
      conv_done_o <= next_conv_done;
    end
  end

  // ---------------- link domain (serial clock) ----------------
  // chip select high holds the frame logic in reset: idle, partial byte dropped
  logic link_rst;
  assign link_rst = cs_n_i || reset_i;
  logic [CMD_BITS-1:0] rx_shift, next_rx_shift;
  logic [BIT_CNT_W-1:0] bit_cnt, next_bit_cnt;
  logic cmd_done, next_cmd_done, started, next_started, next_rx_toggle, next_ack_toggle;
  logic [FRAME_BITS-1:0] tx_shift, next_tx_shift;
  logic dout_fall, dout_rise, oe_fall, oe_rise;
  rx_byte_type next_rx_hold;
  always_comb begin
    next_rx_shift = {rx_shift[CMD_BITS-2:0], din_i};
    next_bit_cnt = (bit_cnt == CMD_LAST_BIT) ? BIT_CNT_ZERO : bit_cnt + BIT_CNT_ONE;
    next_cmd_done = cmd_done || (bit_cnt == CMD_LAST_BIT);
    next_started = 1'b1;
    next_rx_hold = rx_hold;
    next_rx_toggle = rx_toggle;
    next_ack_toggle = ack_toggle;
    next_tx_shift = {tx_shift[FRAME_BITS-2:0], 1'b0};
    if (bit_cnt == CMD_LAST_BIT) begin
      next_rx_hold = '{first: !cmd_done, data: next_rx_shift};
      next_rx_toggle = !rx_toggle;
    end
    // the held result is taken at the frame's first fall; eoc low guards its contents
    // tx_full is settled here: set on the same clock edge that eoc falls, cleared only by this ack
    if (!started) begin
      next_tx_shift = {tx_hold, {(FRAME_BITS-RESULT_BITS){1'b0}}};
      if (tx_full) begin
        next_ack_toggle = !ack_toggle;
      end
    end
  end

  always_ff @(negedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      rx_shift <= BYTE_ZERO;
      bit_cnt <= BIT_CNT_ZERO;
      cmd_done <= 1'b0;
      started <= 1'b0;
      tx_shift <= FRAME_ZERO;
      dout_fall <= 1'b0;
      oe_fall <= 1'b0;
    end else begin
      rx_shift <= next_rx_shift;
      bit_cnt <= next_bit_cnt;
      cmd_done <= next_cmd_done;
      started <= next_started;
      tx_shift <= next_tx_shift;
      dout_fall <= next_tx_shift[FRAME_BITS-1];
      oe_fall <= 1'b1;
    end
  end
  // toggles survive chip select so a frame end cannot fake a hand-off
  always_ff @(negedge sclk_i or posedge reset_i) begin
    if (reset_i) begin
      rx_toggle <= 1'b0;
      ack_toggle <= 1'b0;
      rx_hold <= '0;
    end else begin
      rx_toggle <= cs_n_i ? rx_toggle : next_rx_toggle;
      ack_toggle <= cs_n_i ? ack_toggle : next_ack_toggle;
      rx_hold <= cs_n_i ? rx_hold : next_rx_hold;
    end
  end

  always_ff @(posedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      dout_rise <= 1'b0;
      oe_rise <= 1'b0;
    end else begin
      dout_rise <= tx_shift[FRAME_BITS-1];
      oe_rise <= 1'b1;
    end
  end
  // launch edge picked by the mode latched before the frame; flops feed a plain select
  assign dout_o = (mode_hold == MODE_11) ? dout_rise : dout_fall;
  assign dout_oe_o = oe_fall || oe_rise;
endmodule

// ---- tb/port_assertions.sv ----
// assertion checker for the converter serial port, bound to every instance
// takes the mode input only while chip select is high; it may change mid-frame
`timescale 1ns/1ps
module port_checker
  import converter_port_pkg::*;
#(
  parameter int CONV_CLOCKS_P = CONV_CLOCKS,
  parameter int CONV_DIV_P = CONV_DIV_CYCLES
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic eoc_n_o,
  input wire logic dac_load_n_i,
  input wire logic dac_wakeup_select_i,
  // setup and internal side
  input wire converter_port_pkg::clock_mode_type clock_mode_i,
  input wire logic analog_channel_eleven_i,
  input wire logic result_valid_i,
  input wire logic result_ready_o,
  input wire logic rx_valid_o,
  input wire logic conv_busy_o,
  input wire logic conv_done_o,
  input wire logic [RESULT_BITS-1:0] dac_out_o,
  input wire logic dac_wakeup_high_o
);
  import converter_port_pkg::*;
  localparam int NLO = CONV_CLOCKS_P * CONV_DIV_P - 1;
  localparam int NHI = CONV_CLOCKS_P * CONV_DIV_P + 1;
  clock_mode_type frame_mode;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  // the port freezes its mode per frame, so track it the same way
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      frame_mode <= MODE_00;
    end else if (cs_n_i) begin
      frame_mode <= clock_mode_i;
    end
  end
  sequence s_idle;
    cs_n_i [*8];
  endsequence
  sequence s_shift;
    !cs_n_i && dout_oe_o && $past(dout_oe_o) && $changed(dout_o);
  endsequence
  property p_oe_off;
    cs_n_i |-> !dout_oe_o;
  endproperty
  property p_fall_launch;
    s_shift ##0 (frame_mode != MODE_11) |-> $fell(sclk_i);
  endproperty
  property p_rise_launch;
    s_shift ##0 (frame_mode == MODE_11) |-> $rose(sclk_i);
  endproperty
  property p_rx_quiet;
    s_idle |=> !rx_valid_o;
  endproperty
  property p_eoc_answer;
    result_valid_i && result_ready_o && eoc_n_o && cs_n_i |-> ##2 !eoc_n_o;
  endproperty
  property p_eoc_hold;
    s_idle ##0 !eoc_n_o |=> !eoc_n_o;
  endproperty
  property p_dac_hold;
    dac_load_n_i [*6] |-> $stable(dac_out_o);
  endproperty
  property p_wakeup;
    $fell(reset_i) |=> dac_wakeup_high_o == $past(dac_wakeup_select_i);
  endproperty
  property p_conv_time;
    $rose(conv_busy_o) |-> ##[NLO:NHI] conv_done_o;
  endproperty
  property p_ch11_quiet;
    analog_channel_eleven_i [*6] ##0 !conv_busy_o |=> !conv_busy_o;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("output enabled while deselected");
  a_fall_launch: assert property (p_fall_launch) else $error("data moved off a fall");
  a_rise_launch: assert property (p_rise_launch) else $error("data moved off a rise");
  a_rx_quiet: assert property (p_rx_quiet) else $error("byte while deselected");
  a_eoc_answer: assert property (p_eoc_answer) else $error("flag late after word");
  a_eoc_hold: assert property (p_eoc_hold) else $error("flag dropped with no frame");
  a_dac_hold: assert property (p_dac_hold) else $error("dac moved while held");
  a_wakeup: assert property (p_wakeup) else $error("wake-up level not taken");
  a_conv_time: assert property (p_conv_time) else $error("conversion length off");
  a_ch11_quiet: assert property (p_ch11_quiet) else $error("start on analog pin");
endmodule

bind converter_serial_port port_checker #(
  .CONV_CLOCKS_P(CONV_CLOCKS_P),
  .CONV_DIV_P(CONV_DIV_P)
) u_chk (
  .mclk_i, .reset_i, .sclk_i, .cs_n_i, .dout_o, .dout_oe_o, .eoc_n_o, .dac_load_n_i,
  .dac_wakeup_select_i, .clock_mode_i, .analog_channel_eleven_i, .result_valid_i,
  .result_ready_o, .rx_valid_o, .conv_busy_o, .conv_done_o, .dac_out_o, .dac_wakeup_high_o
);

// ---- tb/host_model.sv ----
// host model: serial bus master on the converter port pins
// assumes frames are only started while no conversion runs
`timescale 1ns/1ps
module host_model (
  // pins toward the port
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o,
  // data back from the port
  input wire logic dout_i,
  input wire logic dout_oe_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  // clock idles low, 48 ns period, still between frames
  task automatic frame(input logic [1:0] mode, input logic [15:0] tx, input int nb,
                       output logic [15:0] rx);
    int k;
    rx = 16'h0000;
    #3.7 cs_n_o = 1'b0;
    for (k = 0; k <= nb; k++) begin
      // one trailing clock leaves a partial byte that must be dropped
      din_o = (k < nb) ? tx[15-k] : ~din_o;
      #12 sclk_o = 1'b1;
      #12 if (mode == 2'b11 && k > 0) rx[16-k] = dout_oe_i ? dout_i : 1'bx;
      #12 sclk_o = 1'b0;
      #12 if (mode != 2'b11 && k < nb) rx[15-k] = dout_oe_i ? dout_i : 1'bx;
    end
    cs_n_o = 1'b1;
    din_o = ~din_o;
  endtask
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench for the converter serial port
// assumes host_model drives the serial pins and the checker is bound
`timescale 1ns/1ps
module tb_top;
  import converter_port_pkg::*;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic sclk_i, cs_n_i, din_i, dout_o, dout_oe_o, eoc_n_o;
  logic convert_start_n_i = 1'b1;
  logic dac_load_n_i = 1'b1;
  logic dac_wakeup_select_i = 1'b0;
  clock_mode_type clock_mode_i = MODE_00;
  logic analog_channel_eleven_i = 1'b0;
  logic result_valid_i = 1'b0;
  logic [11:0] result_data_i = 12'h000;
  logic result_ready_o, rx_valid_o, conv_busy_o, conv_done_o, dac_wakeup_high_o;
  rx_byte_type rx_byte_o;
  logic dac_write_i = 1'b0;
  logic [11:0] dac_code_i = 12'h000;
  logic [11:0] dac_out_o;
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  rx_byte_type rxq[$];
  logic [11:0] expq[$];
  converter_serial_port #(.CONV_CLOCKS_P(2), .CONV_DIV_P(3)) DUT (
    .mclk_i, .reset_i, .sclk_i, .cs_n_i, .din_i, .dout_o, .dout_oe_o, .eoc_n_o,
    .convert_start_n_i, .dac_load_n_i, .dac_wakeup_select_i, .clock_mode_i,
    .analog_channel_eleven_i, .result_valid_i, .result_data_i, .result_ready_o,
    .rx_valid_o, .rx_byte_o, .conv_busy_o, .conv_done_o, .dac_write_i, .dac_code_i,
    .dac_out_o, .dac_wakeup_high_o);
  host_model host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .din_o(din_i), .dout_i(dout_o),
    .dout_oe_i(dout_oe_o));
  always #4 mclk_i = ~mclk_i;
  always @(negedge mclk_i) if (rx_valid_o === 1'b1) rxq.push_back(rx_byte_o);
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      results();
    end
  end
  task check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask
  task results();
    if (n_fail == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task t_reset(input logic sel);
    reset_i <= 1'b1;
    dac_wakeup_select_i <= sel;
    repeat (2) @(posedge mclk_i);
    check(eoc_n_o, 1'b1, "flag low in reset");
    check(dout_oe_o, 1'b0, "driving in reset");
    reset_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    check(dac_wakeup_high_o, sel, "wake-up level");
  endtask
  task push(input logic [11:0] w);
    logic r;
    result_valid_i <= 1'b1;
    result_data_i <= w;
    do begin @(negedge mclk_i); r = result_ready_o; @(posedge mclk_i); end while (r !== 1'b1);
    result_valid_i <= 1'b0;
    expq.push_back(w);
  endtask
  task read_one(input clock_mode_type m);
    logic [15:0] rx;
    logic [11:0] w;
    int n;
    clock_mode_i <= m;
    n = 0;
    do begin @(negedge mclk_i); n++; end while (eoc_n_o !== 1'b0 && n < 20);
    check(eoc_n_o, 1'b0, "no result flag");
    @(posedge mclk_i);
    // flip the mode mid-frame: the frame must keep its starting mode
    fork
      host.frame(m, 16'h0000, 16, rx);
      begin repeat (20) @(posedge mclk_i); clock_mode_i <= clock_mode_type'(~m); end
    join
    w = expq.pop_front();
    check(rx, {w, 4'h0}, "serial result word");
    repeat (10) @(posedge mclk_i);
    if (expq.size() == 0) check(eoc_n_o, 1'b1, "flag not cleared");
  endtask
  task t_rx();
    logic [15:0] rx;
    rxq.delete();
    host.frame(MODE_00, 16'hF800, 5, rx);
    repeat (10) @(posedge mclk_i);
    host.frame(MODE_00, 16'hA53C, 16, rx);
    repeat (10) @(posedge mclk_i);
    check(rxq.size(), 2, "byte count");
    check(rxq[0], {1'b1, 8'hA5}, "command byte");
    check(rxq[1], {1'b0, 8'h3C}, "data byte");
  endtask
  task t_fill();
    logic [11:0] w;
    logic r;
    int n;
    w = 12'h3A0;
    result_valid_i <= 1'b1;
    result_data_i <= w;
    for (n = 0; n < 10; n++) begin
      @(negedge mclk_i);
      r = result_ready_o;
      @(posedge mclk_i);
      if (r === 1'b1) begin
        expq.push_back(w);
        w = w + 12'h001;
        result_data_i <= w;
      end
    end
    result_valid_i <= 1'b0;
    check(r, 1'b0, "never refused");
    check(expq.size() >= 2, 1'b1, "too few held");
    n = 0;
    while (expq.size() > 0 && n < 6) begin read_one(MODE_01); n++; end
    check(expq.size(), 0, "words left");
  endtask
  task t_conv();
    logic busy;
    int n;
    convert_start_n_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    convert_start_n_i <= 1'b1;
    n = 0;
    busy = 1'b0;
    // host keeps the bus idle here
    do begin @(negedge mclk_i); n++; busy |= conv_busy_o; end while (conv_done_o !== 1'b1 && n < 40);
    check(busy, 1'b1, "never busy");
    check(n >= 4 && n <= 12, 1'b1, "conversion length");
    @(posedge mclk_i);
    analog_channel_eleven_i <= 1'b1;
    convert_start_n_i <= 1'b0;
    busy = 1'b0;
    repeat (20) begin @(negedge mclk_i); busy |= conv_busy_o; end
    check(busy, 1'b0, "start taken on analog pin");
    @(posedge mclk_i);
    convert_start_n_i <= 1'b1;
    analog_channel_eleven_i <= 1'b0;
  endtask
  task dac_put(input logic [11:0] c);
    dac_code_i <= c;
    dac_write_i <= 1'b1;
    @(posedge mclk_i);
    dac_write_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
  endtask
  initial begin
    t_reset(1'b0);
    t_rx();
    for (int i = 0; i < 4; i++) begin
      push(12'hB4D ^ 12'(i));
      read_one(clock_mode_type'(i));
    end
    t_fill();
    t_conv();
    dac_put(12'hABC);
    check(dac_out_o, 12'h000, "dac moved while held");
    dac_load_n_i <= 1'b0;
    repeat (8) @(posedge mclk_i);
    check(dac_out_o, 12'hABC, "dac not loaded");
    dac_load_n_i <= 1'b1;
    // the load pin passes a synchroniser: let its release settle before the next write
    repeat (8) @(posedge mclk_i);
    dac_put(12'h123);
    check(dac_out_o, 12'hABC, "dac not held");
    t_reset(1'b1);
    results();
  end
endmodule
